// file: agp_port.sv
// six-pin gpio port with analog sharing, led override and apb registers
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module agp_port
  import agp_pkg::*;
#(
  parameter int P_PIN_COUNT = agp_pkg::PIN_COUNT_DF
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [agp_pkg::AW-1:0]  i_paddr,
  input  wire logic [agp_pkg::DW-1:0]  i_pwdata,
  output logic      [agp_pkg::DW-1:0]  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic [agp_pkg::NPIN-1:0] i_pin_in,
  output logic      [agp_pkg::NPIN-1:0] o_pin_out,
  output logic      [agp_pkg::NPIN-1:0] o_pin_oe,
  output logic      [agp_pkg::NPIN-1:0] o_analog_select,
  input  wire logic                    i_network_led_first_en,
  input  wire logic                    i_network_led_first,
  input  wire logic                    i_network_led_second_en,
  input  wire logic                    i_network_led_second,
  input  wire logic                    i_comparator_ref_output,
  output logic                         o_timer_ext_clock_in,
  output logic                         o_converter_channel_two,
  output logic                         o_comparator_two_pos,
  output logic      [1:0]              o_reference_source_select,
  output logic                         o_port_j_pullup_enable,
  output logic                         o_port_d_pullup_enable,
  output logic                         o_port_e_pullup_enable
);
  import agp_pkg::*;

  localparam bit HAS_J_PU = (P_PIN_COUNT >= PULLUP_J_MIN);

  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] sync_r;
  logic [NPIN-1:0] dir_r;
  logic [NPIN-1:0] dir_nxt;
  logic [NPIN-1:0] lat_r;
  logic [NPIN-1:0] lat_nxt;
  logic [3:0]      analog_pin_select_field_r;
  logic [3:0]      analog_pin_select_field_nxt;
  logic [1:0]      reference_source_select_r;
  logic [1:0]      reference_source_select_nxt;
  logic            pu_j_r;
  logic            pu_j_nxt;
  logic            pu_d_r;
  logic            pu_d_nxt;
  logic            pu_e_r;
  logic            pu_e_nxt;
  agp_apb_e        st_r;
  agp_apb_e        st_nxt;
  logic [DW-1:0]   prdata_r;
  logic [DW-1:0]   prdata_nxt;
  logic            slverr_r;
  logic            slverr_nxt;
  logic [NPIN-1:0] analog_w;
  logic [NPIN-1:0] led_en_w;
  logic [NPIN-1:0] led_w;
  logic [NPIN-1:0] ref_w;
  logic [NPIN-1:0] out_w;
  logic [NPIN-1:0] oe_w;
  logic [NPIN-1:0] rd_w;
  logic [NPIN-1:0] pin_out_r;
  logic [NPIN-1:0] pin_oe_r;
  logic [NPIN-1:0] ana_r;
  logic            tmr_r;
  logic            ch2_r;
  logic            c2p_r;
  logic            wr_done;
  logic            mapped;
  logic [DW-1:0]   rd_val;

  // pins are asynchronous to i_clk; only sync_r is read by logic
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_pin_in;
      sync_r <= meta_r;
    end
  end

  always_comb begin
    led_en_w = '0;
    led_w    = '0;
    ref_w    = '0;
    led_en_w[PIN_LED_A] = i_network_led_first_en;
    led_en_w[PIN_LED_B] = i_network_led_second_en;
    led_w[PIN_LED_A]    = i_network_led_first;
    led_w[PIN_LED_B]    = i_network_led_second;
    ref_w[PIN_REF]      = i_comparator_ref_output;
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      assign analog_w[g] = (analog_pin_select_field_r < ANALOG_PIN_SELECT_FIELD_LIMIT[g]);
      agp_pin u_pin (
        .i_dir     (dir_r[g]),
        .i_lat     (lat_r[g]),
        .i_led_en  (led_en_w[g]),
        .i_led     (led_w[g]),
        .i_ref_out (ref_w[g]),
        .i_analog  (analog_w[g]),
        .i_level   (sync_r[g]),
        .o_out     (out_w[g]),
        .o_oe      (oe_w[g]),
        .o_rd      (rd_w[g])
      );
    end
  endgenerate

  // one wait state: the answer is prepared in the first access cycle,
  // so pready and prdata can come straight from flops
  assign wr_done = i_psel && i_penable && i_pwrite && (st_r == AGP_ST_DONE);
  assign mapped  = (i_paddr == ADDR_PORT) || (i_paddr == ADDR_LAT) ||
                   (i_paddr == ADDR_DIR) || (i_paddr == ADDR_CFG);

  always_comb begin
    rd_val = '0;
    case (i_paddr)
      ADDR_PORT: begin
        rd_val[NPIN-1:0] = rd_w;
        rd_val[BIT_J_PU] = HAS_J_PU & pu_j_r;
      end
      ADDR_LAT: begin
        rd_val[NPIN-1:0] = lat_r;
        rd_val[BIT_D_PU] = pu_d_r;
        rd_val[BIT_E_PU] = pu_e_r;
      end
      ADDR_DIR: begin
        rd_val[NPIN-1:0] = dir_r;
      end
      ADDR_CFG: begin
        rd_val[CFG_ANALOG_PIN_SELECT_FIELD_LSB +: 4] = analog_pin_select_field_r;
        rd_val[CFG_REFERENCE_SOURCE_SELECT_LSB +: 2] = reference_source_select_r;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  always_comb begin
    st_nxt     = st_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    case (st_r)
      AGP_ST_IDLE: begin
        if (i_psel && i_penable) begin
          st_nxt     = AGP_ST_DONE;
          prdata_nxt = i_pwrite ? '0 : rd_val;
          slverr_nxt = !mapped;
        end
      end
      AGP_ST_DONE: begin
        st_nxt     = AGP_ST_IDLE;
        prdata_nxt = '0;
        slverr_nxt = 1'b0;
      end
      default: begin
        st_nxt = AGP_ST_IDLE;
      end
    endcase
  end

  // unimplemented bits are simply never stored
  always_comb begin
    dir_nxt  = dir_r;
    lat_nxt  = lat_r;
    analog_pin_select_field_nxt = analog_pin_select_field_r;
    reference_source_select_nxt = reference_source_select_r;
    pu_j_nxt = pu_j_r;
    pu_d_nxt = pu_d_r;
    pu_e_nxt = pu_e_r;
    if (wr_done) begin
      case (i_paddr)
        ADDR_PORT: begin
          lat_nxt  = i_pwdata[NPIN-1:0];
          pu_j_nxt = HAS_J_PU & i_pwdata[BIT_J_PU];
        end
        ADDR_LAT: begin
          lat_nxt  = i_pwdata[NPIN-1:0];
          pu_d_nxt = i_pwdata[BIT_D_PU];
          pu_e_nxt = i_pwdata[BIT_E_PU];
        end
        ADDR_DIR: begin
          dir_nxt = i_pwdata[NPIN-1:0];
        end
        ADDR_CFG: begin
          analog_pin_select_field_nxt = i_pwdata[CFG_ANALOG_PIN_SELECT_FIELD_LSB +: 4];
          reference_source_select_nxt = i_pwdata[CFG_REFERENCE_SOURCE_SELECT_LSB +: 2];
        end
        default: begin
          dir_nxt = dir_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dir_r    <= DIR_RST;
      lat_r    <= LAT_RST;
      analog_pin_select_field_r   <= ANALOG_PIN_SELECT_FIELD_RST;
      reference_source_select_r   <= REFERENCE_SOURCE_SELECT_RST;
      pu_j_r   <= 1'b0;
      pu_d_r   <= 1'b0;
      pu_e_r   <= 1'b0;
      st_r     <= AGP_ST_IDLE;
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else begin
      dir_r    <= dir_nxt;
      lat_r    <= lat_nxt;
      analog_pin_select_field_r   <= analog_pin_select_field_nxt;
      reference_source_select_r   <= reference_source_select_nxt;
      pu_j_r   <= pu_j_nxt;
      pu_d_r   <= pu_d_nxt;
      pu_e_r   <= pu_e_nxt;
      st_r     <= st_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // pin-side outputs are registered: one cycle behind the control state
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      ana_r     <= '0;
      tmr_r     <= 1'b0;
      ch2_r     <= 1'b0;
      c2p_r     <= 1'b0;
    end else begin
      pin_out_r <= out_w;
      pin_oe_r  <= oe_w;
      ana_r     <= analog_w;
      tmr_r     <= sync_r[PIN_TMR];
      ch2_r     <= analog_w[PIN_REF];
      c2p_r     <= analog_w[PIN_REF];
    end
  end

  assign o_prdata                  = prdata_r;
  assign o_pready                  = (st_r == AGP_ST_DONE);
  assign o_pslverr                 = slverr_r;
  assign o_pin_out                 = pin_out_r;
  assign o_pin_oe                  = pin_oe_r;
  assign o_analog_select           = ana_r;
  assign o_timer_ext_clock_in      = tmr_r;
  assign o_converter_channel_two   = ch2_r;
  assign o_comparator_two_pos      = c2p_r;
  assign o_reference_source_select = reference_source_select_r;
  assign o_port_j_pullup_enable    = pu_j_r;
  assign o_port_d_pullup_enable    = pu_d_r;
  assign o_port_e_pullup_enable    = pu_e_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_OUT_LATCH: assert property ((!dir_r[3] && !i_comparator_ref_output) |=>
      (o_pin_oe[3] && o_pin_out[3] == $past(lat_r[3])))
    else $error("output pin does not drive its latch");
  AST_DIR_FLOAT: assert property (dir_r[5] |=> !o_pin_oe[5])
    else $error("input pin still driven");
  AST_ANA_IN_OFF: assert property ((dir_r[0] && analog_w[0]) |-> !rd_w[0])
    else $error("digital input not disabled on analog pin");
  AST_LED_PRIO: assert property ((!dir_r[1] && i_network_led_second_en) |=>
      (o_pin_out[1] == $past(i_network_led_second)))
    else $error("led does not override latch");
  AST_RST_STATE: assert property (disable iff (1'b0) !i_rstn |=>
      (dir_r == DIR_RST && lat_r == LAT_RST && !pu_d_r && !pu_e_r && !pu_j_r))
    else $error("reset state wrong");
  AST_ANA_DEFAULT: assert property ((analog_pin_select_field_r == ANALOG_PIN_SELECT_FIELD_RST) |->
      (analog_w == ANALOG_PINS))
    else $error("reset analog selection wrong");
  AST_PIN4_DIG: assert property (!analog_w[PIN_TMR] && (rd_w[PIN_TMR] == sync_r[PIN_TMR]))
    else $error("pin 4 became analog");
  AST_REF_OFF: assert property (i_comparator_ref_output |->
      (!rd_w[PIN_REF] ##1 !o_pin_oe[PIN_REF]))
    else $error("pin 2 digital path active with reference out");
  AST_AN2_ROUTE: assert property (analog_w[PIN_REF] |=>
      (o_converter_channel_two && o_comparator_two_pos))
    else $error("pin 2 analog route missing");
  AST_TMR_FOLLOW: assert property (##1 o_timer_ext_clock_in == $past(sync_r[PIN_TMR]))
    else $error("timer clock does not follow pin 4");
  AST_UNIMP_ZERO: assert property ((o_pready && !o_pslverr) |->
      (o_prdata[DW-1:8] == '0))
    else $error("unimplemented bits read nonzero");
  AST_PU_WRITE: assert property ((wr_done && i_paddr == ADDR_LAT) |=>
      (o_port_d_pullup_enable == $past(i_pwdata[BIT_D_PU])))
    else $error("pull-up enable not written");
endmodule

// file: agp_pkg.sv
// register map, field layout and reset values for the analog-shared gpio port
package agp_pkg;
  localparam int          NPIN         = 6;
  localparam int          AW           = 12;
  localparam int          DW           = 32;
  localparam logic [11:0] ADDR_PORT    = 12'h000;
  localparam logic [11:0] ADDR_LAT     = 12'h004;
  localparam logic [11:0] ADDR_DIR     = 12'h008;
  localparam logic [11:0] ADDR_CFG     = 12'h00C;
  localparam int          BIT_J_PU     = 7;
  localparam int          BIT_D_PU     = 7;
  localparam int          BIT_E_PU     = 6;
  localparam int          CFG_ANALOG_PIN_SELECT_FIELD_LSB = 0;
  localparam int          CFG_REFERENCE_SOURCE_SELECT_LSB = 4;
  localparam int          PIN_LED_A    = 0;
  localparam int          PIN_LED_B    = 1;
  localparam int          PIN_REF      = 2;
  localparam int          PIN_TMR      = 4;
  localparam int          PULLUP_J_MIN = 80;
  localparam int          PIN_COUNT_DF = 100;
  localparam logic [5:0]  DIR_RST      = 6'h3F;
  localparam logic [5:0]  LAT_RST      = 6'h00;
  localparam logic [3:0]  ANALOG_PIN_SELECT_FIELD_RST     = 4'h0;
  localparam logic [1:0]  REFERENCE_SOURCE_SELECT_RST     = 2'h0;
  localparam logic [5:0]  ANALOG_PINS  = 6'h2F;
  // a pin is analog while the select field is below its limit; pin 4 never is
  localparam logic [3:0]  ANALOG_PIN_SELECT_FIELD_LIMIT [NPIN] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h0, 4'h3};
  typedef enum logic [0:0] {
    AGP_ST_IDLE = 1'b0,
    AGP_ST_DONE = 1'b1
  } agp_apb_e;
endpackage

// file: agp_pin.sv
// one pin cell: output mux, driver enable and digital input gate
`timescale 1ns/1ns
module agp_pin (
  input  wire logic i_dir,
  input  wire logic i_lat,
  input  wire logic i_led_en,
  input  wire logic i_led,
  input  wire logic i_ref_out,
  input  wire logic i_analog,
  input  wire logic i_level,
  output logic      o_out,
  output logic      o_oe,
  output logic      o_rd
);
  always_comb begin
    // analog selection never touches the output path
    o_out = (i_led_en && !i_dir) ? i_led : i_lat;
    o_oe  = !i_dir && !i_ref_out;
    o_rd  = i_level && !(i_dir && i_analog) && !i_ref_out;
  end
endmodule

// file: tb_top.sv
// self-checking testbench for the analog-shared gpio port
`timescale 1ns/1ns
module tb_top;
  import agp_pkg::*;
  typedef struct packed {
    logic [31:0] big;
    logic [31:0] narrow;
    logic        err;
  } agp_note_s;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, prdata_s;
  logic        pready, pready_s, pslverr, tmr, ch2, cmp2, puj, pud, pue, puj_s;
  logic [5:0]  pin_in = 6'h00;
  logic [5:0]  pin_out, pin_oe, asel;
  logic [1:0]  vsel;
  logic        l1_en = 1'b0;
  logic        l1 = 1'b0;
  logic        l2_en = 1'b0;
  logic        l2 = 1'b0;
  logic        cref = 1'b0;
  logic [5:0]  m_dir, m_cfg;
  logic [7:0]  m_lat;
  logic        m_puj;
  agp_note_s   q[$];
  agp_note_s   cur;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 18;
  logic [31:0] r;
  always #10 clk = ~clk;
  agp_port i_dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_analog_select(asel), .i_network_led_first_en(l1_en),
    .i_network_led_first(l1), .i_network_led_second_en(l2_en), .i_network_led_second(l2),
    .i_comparator_ref_output(cref), .o_timer_ext_clock_in(tmr), .o_converter_channel_two(ch2),
    .o_comparator_two_pos(cmp2), .o_reference_source_select(vsel), .o_port_j_pullup_enable(puj),
    .o_port_d_pullup_enable(pud), .o_port_e_pullup_enable(pue));
  // small variant shares every input; only its port j pull-up may differ
  agp_port #(.P_PIN_COUNT(64)) i_dut_s (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata_s), .o_pready(pready_s),
    .o_pslverr(), .i_pin_in(pin_in), .o_pin_out(), .o_pin_oe(), .o_analog_select(),
    .i_network_led_first_en(l1_en), .i_network_led_first(l1), .i_network_led_second_en(l2_en),
    .i_network_led_second(l2), .i_comparator_ref_output(cref), .o_timer_ext_clock_in(),
    .o_converter_channel_two(), .o_comparator_two_pos(), .o_reference_source_select(),
    .o_port_j_pullup_enable(puj_s), .o_port_d_pullup_enable(), .o_port_e_pullup_enable());
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // own copy of the select decode; pin 4 is never analog
  function automatic logic [5:0] am(input logic [3:0] f);
    am = {f < 4'h3, 1'b0, f < 4'h4, f < 4'h5, f < 4'h6, f < 4'h7};
  endfunction
  function automatic logic [5:0] pexp();
    pexp = pin_in & ~(m_dir & am(m_cfg[3:0])) & ~{3'b000, cref, 2'b00};
  endfunction
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      complete_run();
    end else begin
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    q.push_back('{32'h0, 32'h0, !(a inside {ADDR_PORT, ADDR_LAT, ADDR_DIR, ADDR_CFG})});
    apb(a, 1'b1, d);
    case (a)
      ADDR_PORT: begin
        m_lat[5:0] = d[5:0];
        m_puj = d[7];
      end
      ADDR_LAT: m_lat = d[7:0];
      ADDR_DIR: m_dir = d[5:0];
      ADDR_CFG: m_cfg = d[5:0];
      default: ;
    endcase
  endtask
  task automatic rd(input logic [11:0] a);
    logic [31:0] e;
    e = 32'h0;
    case (a)
      ADDR_PORT: e[7:0] = {m_puj, 1'b0, pexp()};
      ADDR_LAT: e[7:0] = m_lat;
      ADDR_DIR: e[5:0] = m_dir;
      ADDR_CFG: e[5:0] = m_cfg;
      default: ;
    endcase
    q.push_back('{e, (a == ADDR_PORT) ? (e & 32'hFFFFFF7F) : e, !(a inside {ADDR_PORT, ADDR_LAT, ADDR_DIR, ADDR_CFG})});
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic mreset();
    m_dir = 6'h3F;
    m_cfg = 6'h00;
    m_lat = 8'h00;
    m_puj = 1'b0;
  endtask
  task automatic pins();
    pin_in <= 6'($random(seed));
    cyc(4);
  endtask
  always @(posedge clk) begin
    if (rstn === 1'b1 && pready === 1'b1) begin
      cur = (q.size() > 0) ? q.pop_front() : agp_note_s'{32'hFFFFFFFF, 32'hFFFFFFFF, 1'b1};
      chk(prdata, cur.big);
      chk(32'(pslverr), 32'(cur.err));
      chk(prdata_s, cur.narrow);
      chk(32'(pready_s), 32'h1);
    end
  end
  initial begin
    mreset();
    cyc(8);
    rstn <= 1'b1;
    pins();
    chk(32'(pin_oe), 32'h0);
    chk({29'h0, puj, pud, pue}, 32'h0);
    chk(32'(asel), 32'h2F);
    rd(ADDR_PORT);
    rd(ADDR_LAT);
    rd(ADDR_DIR);
    rd(ADDR_CFG);
    $display("test reset done");
    wr(ADDR_DIR, 32'hFFFFFFC0);
    rd(ADDR_DIR);
    wr(ADDR_CFG, 32'hFFFFFFFF);
    rd(ADDR_CFG);
    wr(ADDR_LAT, $random(seed));
    rd(ADDR_LAT);
    chk({30'h0, pud, pue}, {30'h0, m_lat[7:6]});
    wr(12'h010, 32'h000000FF);
    rd(12'h010);
    rd(12'hFFC);
    wr(ADDR_DIR, 32'h3F);
    $display("test register access done");
    for (int f = 0; f < 16; f++) begin
      r = $random(seed);
      wr(ADDR_CFG, {26'h0, r[1:0], 4'(f)});
      pins();
      chk(32'(asel), {26'h0, am(4'(f))});
      chk(32'(vsel), 32'(r[1:0]));
      rd(ADDR_PORT);
    end
    $display("test select decode done");
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_PORT, {24'h0, 2'b10, 6'($random(seed))});
    cyc(2);
    chk(32'(pin_oe), 32'h3F);
    chk(32'(pin_out), 32'(m_lat[5:0]));
    chk({30'h0, puj, puj_s}, 32'h2);
    rd(ADDR_PORT);
    rd(ADDR_LAT);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      l1_en <= r[0];
      l1 <= r[1];
      l2_en <= r[2];
      l2 <= r[3];
      cyc(2);
      chk({30'h0, pin_out[1:0]}, {30'h0, (r[2] && !m_dir[1]) ? r[3] : m_lat[1], (r[0] && !m_dir[0]) ? r[1] : m_lat[0]});
      wr(ADDR_DIR, {26'h0, r[9:4]});
      cyc(2);
      chk(32'(pin_oe), {26'h0, ~m_dir});
    end
    $display("test drive and led done");
    wr(ADDR_DIR, 32'h0);
    cref <= 1'b1;
    pins();
    chk(32'(pin_oe[2]), 32'h0);
    rd(ADDR_PORT);
    cref <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_DIR, $random(seed));
      wr(ADDR_CFG, $random(seed));
      pins();
      chk(32'(tmr), 32'(pin_in[4]));
      chk(32'(ch2), 32'(m_cfg[3:0] < 4'h5));
      chk(32'(cmp2), 32'(m_cfg[3:0] < 4'h5));
    end
    $display("test reference and timer done");
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    mreset();
    cyc(3);
    chk(32'(asel), 32'h2F);
    rd(ADDR_DIR);
    rd(ADDR_LAT);
    rd(ADDR_PORT);
    cyc(2);
    chk(32'(q.size()), 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
